// File: rtl/fpa_pkg.sv
// Constants, types and field layouts shared by the add-immediate unit
package fpa_pkg;

    // Register byte offsets within the slave window
    localparam logic [11:0] OFS_CTRL     = 12'h000;
    localparam logic [11:0] OFS_INSN     = 12'h004;
    localparam logic [11:0] OFS_FLAGS    = 12'h008;
    localparam logic [11:0] OFS_CR0      = 12'h00C;
    localparam logic [11:0] OFS_STATUS   = 12'h010;
    localparam logic [3:0]  GPR_REGION   = 4'h1;
    localparam int          GPR_HALF_BIT = 2;
    localparam int          GPR_COUNT    = 32;

    // Register field positions and widths
    localparam int MODE64_BIT  = 0;
    localparam int ILLEGAL_BIT = 0;
    localparam int XER_W       = 3;
    localparam int CR0_W       = 4;

    // Instruction field positions (bit 0 of the word is the LSB here)
    localparam int OPC_HI  = 31;
    localparam int OPC_LO  = 26;
    localparam int TGT_HI  = 25;
    localparam int TGT_LO  = 21;
    localparam int SRCA_HI = 20;
    localparam int SRCA_LO = 16;
    localparam int SRCB_HI = 15;
    localparam int SRCB_LO = 11;
    localparam int OE_BIT  = 10;
    localparam int XO_HI   = 9;
    localparam int XO_LO   = 1;
    localparam int RC_BIT  = 0;
    localparam int IMM_HI  = 15;
    localparam int IMM_LO  = 0;

    // Opcode values
    localparam logic [5:0] OPC_ADDI      = 6'h0E;
    localparam logic [5:0] OPC_ADDIC     = 6'h0C;
    localparam logic [5:0] OPC_ADDIC_REC = 6'h0D;
    localparam logic [5:0] OPC_ADDIS     = 6'h0F;
    localparam logic [5:0] OPC_EXT       = 6'h1F;
    localparam logic [8:0] XO_ADDE       = 9'h08A;

    // Bus encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic       HRESP_OKAY = 1'h0;

    // Reset values
    localparam logic        MODE64_RST  = 1'h0;
    localparam logic        ILLEGAL_RST = 1'h0;
    localparam logic [63:0] GPR_RST     = 64'h0;
    localparam logic [31:0] WORD_RST    = 32'h0;

    // Exception flags and condition field
    typedef struct packed {
        logic so;
        logic ov;
        logic ca;
    } fpa_xer_t;

    typedef struct packed {
        logic lt;
        logic gt;
        logic eq;
        logic so;
    } fpa_cr0_t;

    localparam fpa_xer_t XER_RST = '{so: 1'b0, ov: 1'b0, ca: 1'b0};
    localparam fpa_cr0_t CR0_RST = '{lt: 1'b0, gt: 1'b0, eq: 1'b0, so: 1'b0};

    // Data phase state of the bus slave
    typedef enum logic [3:0] {
        DP_NONE   = 4'b0001,
        DP_WRITE  = 4'b0010,
        DP_RDWAIT = 4'b0100,
        DP_RDDONE = 4'b1000
    } fpa_dp_t;

endpackage : fpa_pkg

// File: rtl/fpa_adder.sv
// 32-bit adder with carry out and signed overflow
module fpa_adder (
    // Operands
    input  wire logic [31:0] opA,
    input  wire logic [31:0] opB,
    input  wire logic        carryIn,
    // Results
    output logic      [31:0] sum,
    output logic             carryOut,
    output logic             overflow
);
    import fpa_pkg::*;

    logic [32:0] wide;

    // One extra bit catches the unsigned carry
    assign wide     = {1'b0, opA} + {1'b0, opB} + {32'h0, carryIn};
    assign sum      = wide[31:0];
    assign carryOut = wide[32];
    // Signed overflow: like signs in, other sign out
    assign overflow = (opA[31] == opB[31]) && (wide[31] != opA[31]);

endmodule : fpa_adder

// File: rtl/fpa_add_imm_unit.sv
// Add-immediate execute unit with register file behind an AHB-Lite slave
//
// Added by the designer: the AHB-Lite register port and the address map.
module fpa_add_imm_unit (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp
);
    import fpa_pkg::*;

    // Bus slave state
    fpa_dp_t     dpState_ff;
    fpa_dp_t     nxt_dpState;
    logic [11:0] dpAddr_ff;
    logic        dpLive_ff;
    logic [31:0] hrdata_ff;
    logic [31:0] readMux;
    logic        addrTaken;
    logic        addrLive;
    logic        wrFire;
    logic        execFire;

    // Architectural state
    logic [63:0] gpr_ff [GPR_COUNT];
    fpa_xer_t    xer_ff;
    fpa_cr0_t    cr0_ff;
    logic        mode64_ff;
    logic        illegal_ff;
    logic [31:0] lastInsn_ff;

    // Decode
    logic [5:0]  opc;
    logic [8:0]  xo;
    logic [4:0]  tgtIdx;
    logic [4:0]  srcAIdx;
    logic [4:0]  srcBIdx;
    logic [15:0] imm16;
    logic        isAddi;
    logic        isAddic;
    logic        isAddicRec;
    logic        isAddis;
    logic        isAdde;
    logic        legal;
    logic        srcAZero;
    logic        recordOn;
    logic        oeOn;
    logic        carryOn;

    // Datapath
    logic [31:0] gprA;
    logic [31:0] gprB;
    logic [31:0] immSext;
    logic [31:0] immShift;
    logic [31:0] opA;
    logic [31:0] opB;
    logic        cin;
    logic [31:0] sumLo;
    logic [31:0] resUpper;
    logic        coutBit;
    logic        ovBit;
    logic        newSo;

    // Address phase: accepted whenever selected, the bus is ready and it is NONSEQ/SEQ
    assign addrTaken = hsel && htrans[1] && hready;
    // Only aligned word accesses inside the window have an effect
    assign addrLive  = (haddr[31:12] == 20'h0) && (haddr[1:0] == 2'h0) && (hsize == HSIZE_WORD);

    // Next data phase follows from the address phase just taken
    always_comb begin
        nxt_dpState = DP_NONE;
        unique case (dpState_ff)
            DP_RDWAIT: begin
                nxt_dpState = DP_RDDONE;
            end
            DP_NONE, DP_WRITE, DP_RDDONE: begin
                if (addrTaken) begin
                    nxt_dpState = hwrite ? DP_WRITE : DP_RDWAIT;
                end
            end
            default: begin
                nxt_dpState = DP_NONE;
            end
        endcase
    end

    // Data phase tracking
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dpState_ff <= DP_NONE;
            dpAddr_ff  <= 12'h000;
            dpLive_ff  <= 1'b0;
        end else begin
            dpState_ff <= nxt_dpState;
            if (addrTaken) begin
                dpAddr_ff <= haddr[11:0];
                dpLive_ff <= addrLive;
            end
        end
    end

    // Reads take one wait state so that the data comes from a flip-flop
    assign hreadyout = (dpState_ff != DP_RDWAIT);
    assign hresp     = HRESP_OKAY;
    assign hrdata    = hrdata_ff;
    assign wrFire    = (dpState_ff == DP_WRITE) && dpLive_ff;
    assign execFire  = wrFire && (dpAddr_ff == OFS_INSN);

    // Read multiplexer; unmapped offsets read as zero
    always_comb begin
        readMux = WORD_RST;
        if (dpLive_ff) begin
            if (dpAddr_ff[11:8] == GPR_REGION) begin
                readMux = dpAddr_ff[GPR_HALF_BIT] ? gpr_ff[dpAddr_ff[7:3]][63:32]
                                                  : gpr_ff[dpAddr_ff[7:3]][31:0];
            end else begin
                case (dpAddr_ff)
                    OFS_CTRL:   readMux = {31'h0, mode64_ff};
                    OFS_INSN:   readMux = lastInsn_ff;
                    OFS_FLAGS:  readMux = {29'h0, xer_ff};
                    OFS_CR0:    readMux = {28'h0, cr0_ff};
                    OFS_STATUS: readMux = {31'h0, illegal_ff};
                    default:    readMux = WORD_RST;
                endcase
            end
        end
    end

    // Read data register, loaded in the wait cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_ff <= WORD_RST;
        end else if (dpState_ff == DP_RDWAIT) begin
            hrdata_ff <= readMux;
        end
    end

    // Instruction fields, taken straight from the write data of the issue word
    assign opc     = hwdata[OPC_HI:OPC_LO];
    assign xo      = hwdata[XO_HI:XO_LO];
    assign tgtIdx  = hwdata[TGT_HI:TGT_LO];
    assign srcAIdx = hwdata[SRCA_HI:SRCA_LO];
    assign srcBIdx = hwdata[SRCB_HI:SRCB_LO];
    assign imm16   = hwdata[IMM_HI:IMM_LO];

    // Opcode decode
    assign isAddi     = (opc == OPC_ADDI);
    assign isAddic    = (opc == OPC_ADDIC);
    assign isAddicRec = (opc == OPC_ADDIC_REC);
    assign isAddis    = (opc == OPC_ADDIS);
    assign isAdde     = (opc == OPC_EXT) && (xo == XO_ADDE);
    assign legal      = isAddi || isAddic || isAddicRec || isAddis || isAdde;
    assign srcAZero   = (srcAIdx == 5'h00);
    // Flag update controls per form
    assign carryOn  = isAddic || isAddicRec || isAdde;
    assign oeOn     = isAdde && hwdata[OE_BIT];
    assign recordOn = isAddicRec || (isAdde && hwdata[RC_BIT]);

    // Operand selection
    assign gprA     = gpr_ff[srcAIdx][31:0];
    assign gprB     = gpr_ff[srcBIdx][31:0];
    assign immSext  = {{16{imm16[15]}}, imm16};
    assign immShift = {imm16, 16'h0000};
    // Register 0 reads as zero only for the plain and shifted forms
    assign opA = ((isAddi || isAddis) && srcAZero) ? WORD_RST : gprA;
    assign opB = isAdde ? gprB : (isAddis ? immShift : immSext);
    assign cin = isAdde && xer_ff.ca;

    fpa_adder u_adder (
        .opA      (opA),
        .opB      (opB),
        .carryIn  (cin),
        .sum      (sumLo),
        .carryOut (coutBit),
        .overflow (ovBit)
    );

    // Upper word: sign copy only for the shifted form in wide mode
    assign resUpper = (isAddis && mode64_ff) ? {32{sumLo[31]}} : WORD_RST;
    // Summary overflow is sticky; a new overflow joins it
    assign newSo    = xer_ff.so || (oeOn && ovBit);

    // General-purpose registers: execution or direct bus access
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < GPR_COUNT; i++) begin
                gpr_ff[i] <= GPR_RST;
            end
        end else if (execFire && legal) begin
            gpr_ff[tgtIdx] <= {resUpper, sumLo};
        end else if (wrFire && (dpAddr_ff[11:8] == GPR_REGION)) begin
            if (dpAddr_ff[GPR_HALF_BIT]) begin
                gpr_ff[dpAddr_ff[7:3]][63:32] <= hwdata;
            end else begin
                gpr_ff[dpAddr_ff[7:3]][31:0] <= hwdata;
            end
        end
    end

    // Exception flags; the plain and shifted forms leave them alone
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            xer_ff <= XER_RST;
        end else if (execFire && legal) begin
            if (carryOn) begin
                xer_ff.ca <= coutBit;
            end
            if (oeOn) begin
                xer_ff.ov <= ovBit;
                xer_ff.so <= newSo;
            end
        end else if (wrFire && (dpAddr_ff == OFS_FLAGS)) begin
            xer_ff <= fpa_xer_t'(hwdata[XER_W-1:0]);
        end
    end

    // Condition field 0, written only by recording forms or a direct bus write
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cr0_ff <= CR0_RST;
        end else if (execFire && legal && recordOn) begin
            cr0_ff.lt <= sumLo[31];
            cr0_ff.gt <= !sumLo[31] && (sumLo != WORD_RST);
            cr0_ff.eq <= (sumLo == WORD_RST);
            cr0_ff.so <= newSo;
        end else if (wrFire && (dpAddr_ff == OFS_CR0)) begin
            cr0_ff <= fpa_cr0_t'(hwdata[CR0_W-1:0]);
        end
    end

    // Control, last issued word and illegal flag (set beats clear)
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode64_ff   <= MODE64_RST;
            illegal_ff  <= ILLEGAL_RST;
            lastInsn_ff <= WORD_RST;
        end else begin
            if (wrFire && (dpAddr_ff == OFS_CTRL)) begin
                mode64_ff <= hwdata[MODE64_BIT];
            end
            if (execFire) begin
                lastInsn_ff <= hwdata;
            end
            if (execFire && !legal) begin
                illegal_ff <= 1'b1;
            end else if (wrFire && (dpAddr_ff == OFS_STATUS) && hwdata[ILLEGAL_BIT]) begin
                illegal_ff <= 1'b0;
            end
        end
    end

    // Reference values seen only by the checks below
    logic [32:0] refSum;
    logic [31:0] refLo;
    logic        refCarry;
    logic        refOv;
    assign refSum   = {1'b0, opA} + {1'b0, opB} + {32'h0, cin};
    assign refLo    = refSum[31:0];
    assign refCarry = refSum[32];
    assign refOv    = (opA[31] == opB[31]) && (refSum[31] != opA[31]);

    sequence s_issue(logic form);
        execFire && form;
    endsequence

    a_addi_sum: assert property (@(posedge mclk) disable iff (!rst_n)
        s_issue(isAddi && !srcAZero) |=> gpr_ff[$past(tgtIdx)][31:0] ==
            $past(gprA) + $past(immSext)) else $error("addi sum wrong");
    a_addi_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        s_issue(isAddi && srcAZero) |=> gpr_ff[$past(tgtIdx)][31:0] ==
            $past(immSext)) else $error("addi with r0 wrong");
    a_addi_flags: assert property (@(posedge mclk) disable iff (!rst_n)
        s_issue(isAddi) |=> $stable(xer_ff) && $stable(cr0_ff))
        else $error("addi changed flags");
    a_addic_sext: assert property (@(posedge mclk) disable iff (!rst_n)
        s_issue(isAddic || isAddicRec) |=> gpr_ff[$past(tgtIdx)][31:0] ==
            $past(gprA) + $past(immSext)) else $error("addic sum wrong");
    a_addic_carry: assert property (@(posedge mclk) disable iff (!rst_n)
        s_issue(isAddic) |=> xer_ff.ca == $past(refCarry) && $stable(cr0_ff))
        else $error("addic carry or cr0 wrong");
    a_addicr_cr0: assert property (@(posedge mclk) disable iff (!rst_n)
        s_issue(isAddicRec) |=> cr0_ff.eq == (gpr_ff[$past(tgtIdx)][31:0] == 32'h0)
            && cr0_ff.so == xer_ff.so && xer_ff.ca == $past(refCarry))
        else $error("addic record wrong");
    a_addis_sum: assert property (@(posedge mclk) disable iff (!rst_n)
        s_issue(isAddis && !srcAZero) |=> gpr_ff[$past(tgtIdx)][31:0] ==
            $past(gprA) + {$past(imm16), 16'h0000}) else $error("addis sum wrong");
    a_addis_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        s_issue(isAddis && srcAZero) |=> gpr_ff[$past(tgtIdx)][31:0] ==
            {$past(imm16), 16'h0000}) else $error("addis with r0 wrong");
    a_addis_flags: assert property (@(posedge mclk) disable iff (!rst_n)
        s_issue(isAddis) |=> $stable(xer_ff) && $stable(cr0_ff))
        else $error("addis changed flags");
    a_addis_upper: assert property (@(posedge mclk) disable iff (!rst_n)
        s_issue(isAddis) |=> gpr_ff[$past(tgtIdx)][63:32] == ($past(mode64_ff) ?
            {32{gpr_ff[$past(tgtIdx)][31]}} : 32'h0)) else $error("upper word wrong");
    a_signed_lt: assert property (@(posedge mclk) disable iff (!rst_n)
        execFire && recordOn |=> cr0_ff.lt == gpr_ff[$past(tgtIdx)][31])
        else $error("cr0 lt not sign of result");
    a_adde_sum: assert property (@(posedge mclk) disable iff (!rst_n)
        s_issue(isAdde) |=> gpr_ff[$past(tgtIdx)][31:0] == $past(refLo) &&
            $past(refLo) == $past(gprA) + $past(gprB) + {31'h0, $past(xer_ff.ca)})
        else $error("adde sum wrong");
    a_adde_carry: assert property (@(posedge mclk) disable iff (!rst_n)
        s_issue(isAdde) |=> xer_ff.ca == $past(refCarry))
        else $error("adde carry wrong");
    a_adde_ovf: assert property (@(posedge mclk) disable iff (!rst_n)
        s_issue(isAdde) |=> ($past(oeOn) ? (xer_ff.ov == $past(refOv) &&
            xer_ff.so == ($past(xer_ff.so) || $past(refOv))) :
            (xer_ff.ov == $past(xer_ff.ov) && xer_ff.so == $past(xer_ff.so))))
        else $error("overflow update wrong");
    a_record_cr0: assert property (@(posedge mclk) disable iff (!rst_n)
        s_issue(isAdde && !hwdata[RC_BIT]) |=> $stable(cr0_ff))
        else $error("cr0 changed without record");
    a_record_gt: assert property (@(posedge mclk) disable iff (!rst_n)
        s_issue(isAdde && hwdata[RC_BIT]) |=> cr0_ff.gt == (!$past(refLo[31]) &&
            $past(refLo) != 32'h0)) else $error("cr0 gt wrong");
    a_decode_bad: assert property (@(posedge mclk) disable iff (!rst_n)
        execFire && !legal |=> illegal_ff && $stable(xer_ff) && $stable(cr0_ff))
        else $error("illegal opcode not caught");

endmodule : fpa_add_imm_unit

// File: test/fpa_ahb_master.sv
// Single-transfer AHB-Lite master model for the unit's slave port
module fpa_ahb_master
    import fpa_pkg::*;
(
    // Clock
    input  wire logic        mclk,
    // Bus towards the slave
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus from time zero
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = HSIZE_WORD;
        hwdata = 32'h0;
    end

    // One word transfer; called just after a rising edge, returns just after one
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output bit to);
        int n;
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= HSIZE_WORD;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        // A stalled address phase counts as a timeout too
        to = (hready !== 1'b1);
        htrans <= 2'h0;
        // Reads see no stale write data on the bus
        hwdata <= w ? wd : ~a;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        rd = hrdata;
        to = to || (hready !== 1'b1);
    endtask : xfer
endmodule : fpa_ahb_master

// File: test/fixed_point_add_immediate_unit_tb_top.sv
// Self-checking bench for the add-immediate unit
module fixed_point_add_immediate_unit_tb_top import fpa_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    int          errorCnt;
    int          checkCount;

    // Clock at 250 MHz
    initial mclk = 1'b0;
    always #2 mclk = ~mclk;

    fpa_add_imm_unit DUT (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

    fpa_ahb_master uBus (.mclk(mclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata));

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checkCount, errorCnt);
        if (errorCnt == 0 && checkCount > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bit          to;
        uBus.xfer(1'b1, a, d, r, to);
        if (to) begin
            errorCnt++;
            give_verdict();
        end
    endtask : wr

    // Read compare; response code travels with the data
    task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        bit          to;
        uBus.xfer(1'b0, a, 32'h0, r, to);
        if (to) begin
            errorCnt++;
            give_verdict();
        end
        checkCount++;
        if ({hresp, r} !== {HRESP_OKAY, e}) begin
            errorCnt++;
            $display("mismatch at %0t addr %h got %h expected %h", $time, a, {hresp, r},
                     {HRESP_OKAY, e});
        end
    endtask : rdchk

    function automatic logic [31:0] ga(input int n);
        return 32'h100 + 32'(8 * n);
    endfunction : ga

    function automatic logic [31:0] dfm(input logic [5:0] o, input logic [4:0] t,
                                        input logic [4:0] a, input logic [15:0] i);
        return {o, t, a, i};
    endfunction : dfm

    function automatic logic [31:0] xfm(input logic [4:0] t, input logic [4:0] a,
                                        input logic [4:0] b, input logic oe, input logic rc);
        return {OPC_EXT, t, a, b, oe, XO_ADDE, rc};
    endfunction : xfm

    task automatic t_reset;
        rdchk(32'(OFS_FLAGS), 32'h0);
        rdchk(32'(OFS_CR0), 32'h0);
        rdchk(ga(7) + 32'h4, 32'h0);
        rdchk(32'h0000_0020, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_addi;
        wr(ga(0), 32'h55);
        wr(ga(5), 32'h900);
        wr(32'(OFS_FLAGS), 32'h7);
        wr(32'(OFS_CR0), 32'hA);
        wr(32'(OFS_INSN), dfm(OPC_ADDI, 5'd4, 5'd5, 16'h8FF0));
        rdchk(ga(4), 32'hFFFF_98F0);
        wr(32'(OFS_INSN), dfm(OPC_ADDI, 5'd3, 5'd0, 16'h8001));
        rdchk(ga(3), 32'hFFFF_8001);
        rdchk(32'(OFS_FLAGS), 32'h7);
        rdchk(32'(OFS_CR0), 32'hA);
        $display("test addi done");
    endtask : t_addi

    task automatic t_addic;
        wr(32'(OFS_FLAGS), 32'h0);
        wr(32'(OFS_CR0), 32'h6);
        wr(ga(4), 32'h2346);
        wr(32'(OFS_INSN), dfm(OPC_ADDIC, 5'd6, 5'd4, 16'hFFFF));
        rdchk(ga(6), 32'h2345);
        rdchk(32'(OFS_FLAGS), 32'h1);
        wr(32'(OFS_INSN), dfm(OPC_ADDIC, 5'd6, 5'd4, 16'h0001));
        rdchk(32'(OFS_FLAGS), 32'h0);
        rdchk(32'(OFS_CR0), 32'h6);
        $display("test addic done");
    endtask : t_addic

    task automatic t_addic_rec;
        wr(32'(OFS_FLAGS), 32'h4);
        wr(ga(4), 32'hEFFF_FFFF);
        wr(32'(OFS_INSN), dfm(OPC_ADDIC_REC, 5'd6, 5'd4, 16'h1000));
        rdchk(ga(6), 32'hF000_0FFF);
        rdchk(32'(OFS_FLAGS), 32'h4);
        rdchk(32'(OFS_CR0), 32'h9);
        wr(ga(4), 32'hFFFF_FFFF);
        wr(32'(OFS_INSN), dfm(OPC_ADDIC_REC, 5'd6, 5'd4, 16'h0001));
        rdchk(32'(OFS_FLAGS), 32'h5);
        rdchk(32'(OFS_CR0), 32'h3);
        $display("test addic record done");
    endtask : t_addic_rec

    task automatic t_addis;
        wr(32'(OFS_FLAGS), 32'h2);
        wr(32'(OFS_CR0), 32'h3);
        wr(ga(6), 32'h4000);
        wr(32'(OFS_INSN), dfm(OPC_ADDIS, 5'd7, 5'd6, 16'h0011));
        rdchk(ga(7), 32'h0011_4000);
        wr(32'(OFS_INSN), dfm(OPC_ADDIS, 5'd8, 5'd0, 16'h8000));
        rdchk(ga(8), 32'h8000_0000);
        rdchk(ga(8) + 32'h4, 32'h0);
        rdchk(32'(OFS_FLAGS), 32'h2);
        rdchk(32'(OFS_CR0), 32'h3);
        wr(32'(OFS_CTRL), 32'h1);
        rdchk(32'(OFS_CTRL), 32'h1);
        wr(32'(OFS_INSN), dfm(OPC_ADDIS, 5'd8, 5'd0, 16'h8000));
        rdchk(ga(8) + 32'h4, 32'hFFFF_FFFF);
        wr(32'(OFS_INSN), dfm(OPC_ADDIS, 5'd8, 5'd0, 16'h7000));
        rdchk(ga(8) + 32'h4, 32'h0);
        wr(32'(OFS_CTRL), 32'h0);
        $display("test addis done");
    endtask : t_addis

    task automatic t_adde;
        wr(32'(OFS_FLAGS), 32'h3);
        wr(ga(4), 32'h1000_0400);
        wr(ga(10), 32'h1000_0400);
        wr(32'(OFS_INSN), xfm(5'd6, 5'd4, 5'd10, 1'b0, 1'b0));
        rdchk(ga(6), 32'h2000_0801);
        rdchk(32'(OFS_FLAGS), 32'h2);
        wr(32'(OFS_FLAGS), 32'h1);
        wr(ga(10), 32'hEFFF_FFFF);
        wr(32'(OFS_INSN), xfm(5'd6, 5'd4, 5'd10, 1'b1, 1'b0));
        rdchk(ga(6), 32'h0000_0400);
        rdchk(32'(OFS_FLAGS), 32'h1);
        wr(32'(OFS_FLAGS), 32'h0);
        wr(ga(4), 32'h9000_3000);
        wr(ga(10), 32'h8000_7000);
        wr(32'(OFS_INSN), xfm(5'd6, 5'd4, 5'd10, 1'b1, 1'b1));
        rdchk(ga(6), 32'h1000_A000);
        rdchk(32'(OFS_FLAGS), 32'h7);
        rdchk(32'(OFS_CR0), 32'h5);
        $display("test adde done");
    endtask : t_adde

    // Unknown opcode: nothing changes but the sticky status bit and the last issued word
    task automatic t_illegal;
        wr(32'(OFS_INSN), dfm(6'h01, 5'd9, 5'd4, 16'h0001));
        rdchk(32'(OFS_STATUS), 32'h1);
        rdchk(32'(OFS_INSN), dfm(6'h01, 5'd9, 5'd4, 16'h0001));
        rdchk(ga(9), 32'h0);
        rdchk(32'(OFS_FLAGS), 32'h7);
        rdchk(32'(OFS_CR0), 32'h5);
        wr(32'(OFS_STATUS), 32'h1);
        rdchk(32'(OFS_STATUS), 32'h0);
        wr(32'(OFS_CTRL), 32'h1);
        wr(32'(OFS_INSN), dfm(OPC_ADDI, 5'd9, 5'd0, 16'h8000));
        rdchk(ga(9), 32'hFFFF_8000);
        rdchk(ga(9) + 32'h4, 32'h0);
        wr(32'(OFS_CTRL), 32'h0);
        $display("test illegal done");
    endtask : t_illegal

    // Reset for 20 cycles, then the scenarios in turn
    initial begin
        errorCnt   = 0;
        checkCount = 0;
        rst_n      = 1'b0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_addi();
        t_addic();
        t_addic_rec();
        t_addis();
        t_adde();
        t_illegal();
        give_verdict();
    end
endmodule : fixed_point_add_immediate_unit_tb_top
